// ==== design/camcap_pkg.sv ====
// Shared constants and types of the camera capture port
package camcap_pkg;
    // Bus widths and buffer size
    localparam int DATA_W     = 20;
    localparam int COMP_W     = 10;
    localparam int FIFO_DEPTH = 8;

    // Embedded timing code words, seen on the upper eight luma pins
    localparam logic [7:0] CODE_PRE  = 8'hFF;
    localparam logic [7:0] CODE_ZERO = 8'h00;
    localparam int         XY_V_BIT  = 5;
    localparam int         XY_H_BIT  = 4;

    // Field positions on the data pins
    localparam int LANE8_LO  = 12;
    localparam int C16_LO    = 4;
    localparam int C1120_LO  = 2;
    localparam int Y20_LO    = 10;
    localparam int C20_LO    = 0;
    localparam int B16_LO    = 4;
    localparam int G16_LO    = 9;
    localparam int R16_LO    = 15;

    // Format select: timing mode and pin mapping in one field
    typedef enum logic [3:0] {
        FMT_RGB565_2C,
        FMT_RGB565_3C,
        FMT_RGB666_3C,
        FMT_RGB888_3C,
        FMT_YCC8_656,
        FMT_RGB565_16,
        FMT_YCC16_GEN,
        FMT_YCC16_1120,
        FMT_YCC20_1120
    } camcap_fmt_t;

    // Embedded code preamble tracker
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_FF,
        SEQ_Z1,
        SEQ_Z2
    } camcap_seq_t;

    // One captured pixel with its frame and line markers
    typedef struct packed {
        logic              frame_start;
        logic              line_start;
        logic [COMP_W-1:0] comp_a;
        logic [COMP_W-1:0] comp_b;
        logic [COMP_W-1:0] comp_c;
    } camcap_pix_t;
endpackage : camcap_pkg

// ==== design/camcap_fifo.sv ====
// Pixel FIFO with registered output stage
`timescale 1ns/10ps
`default_nettype none
module camcap_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      count_ff;
    logic             out_valid_ff;
    logic [WIDTH-1:0] out_data_ff;

    // Write and refill decisions
    wire push = in_valid & in_ready;
    wire load = (count_ff != '0) & (~out_valid_ff | out_ready);
    wire [AW-1:0] wr_nxt = (wr_ptr_ff == AW'(DEPTH - 1)) ? '0
                                                          : wr_ptr_ff + 1'b1;
    wire [AW-1:0] rd_nxt = (rd_ptr_ff == AW'(DEPTH - 1)) ? '0
                                                          : rd_ptr_ff + 1'b1;

    assign in_ready  = (count_ff != (AW+1)'(DEPTH));
    assign out_valid = out_valid_ff;
    assign out_data  = out_data_ff;

    // Storage has no reset; pointers, count and output stage do
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (push) wr_ptr_ff <= wr_nxt;
            if (load) rd_ptr_ff <= rd_nxt;
            count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(load);
        end
    end

    // Output register keeps the port glitch free
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            out_valid_ff <= 1'b0;
            out_data_ff  <= '0;
        end else if (load) begin
            out_valid_ff <= 1'b1;
            out_data_ff  <= mem[rd_ptr_ff];
        end else if (out_ready) begin
            out_valid_ff <= 1'b0;
        end
    end
endmodule : camcap_fifo
`default_nettype wire

// ==== design/camcap_top.sv ====
// Parallel camera capture port: sync recovery, pin mapping, pixel FIFO
`timescale 1ns/10ps
`default_nettype none
module camcap_top #(
    parameter int FIFO_DEPTH = camcap_pkg::FIFO_DEPTH
) (
    input  wire logic                           clock,
    input  wire logic                           rst_n,
    input  wire logic                           pixel_clock_in,
    input  wire logic                           frame_sync_in,
    input  wire logic                           line_sync_in,
    input  wire logic [camcap_pkg::DATA_W-1:0]  sensor_data_bus,
    input  wire camcap_pkg::camcap_fmt_t        fmt_sel,
    input  wire logic                           generic_en,
    input  wire logic                           invert_frame_sync,
    input  wire logic                           invert_line_sync,
    output var  camcap_pkg::camcap_pix_t        pix_out,
    output logic                                pix_valid,
    input  wire logic                           pix_ready,
    output logic                                frame_sync_out,
    output logic                                line_sync_out,
    output logic                                overflow_out
);
    localparam int DW    = camcap_pkg::DATA_W;
    localparam int CW    = camcap_pkg::COMP_W;
    localparam int NSYNC = DW + 3;
    localparam int PCLK_IDX = DW + 2;
    localparam int FS_IDX   = DW + 1;
    localparam int LS_IDX   = DW;

    logic [NSYNC-1:0]        s1_ff, s2_ff, s3_ff, stab_ff;
    logic                    pclk_prev_ff, fs_prev_ff, ls_prev_ff;
    camcap_pkg::camcap_seq_t seq_ff;
    logic                    v_ff, active_ff;
    logic [1:0]              phase_ff;
    logic [7:0]              w0_ff, w1_ff;
    logic                    frame_pend_ff, line_pend_ff;
    logic                    frame_sync_out_ff, line_sync_out_ff;
    logic                    overflow_ff;
    logic                    fifo_ready;

    // Three-stage synchronisers on every pin
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else begin
            s1_ff <= {pixel_clock_in, frame_sync_in, line_sync_in,
                      sensor_data_bus};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // A level is accepted only once stages two and three agree
    for (genvar i = 0; i < NSYNC; i++) begin : g_stab
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                stab_ff[i] <= 1'b0;
            end else if (s2_ff[i] == s3_ff[i]) begin
                stab_ff[i] <= s3_ff[i];
            end
        end
    end

    // Clean levels after optional polarity swap
    wire          pclk_q = stab_ff[PCLK_IDX];
    wire          fs_lvl = stab_ff[FS_IDX] ^ invert_frame_sync;
    wire          ls_lvl = stab_ff[LS_IDX] ^ invert_line_sync;
    wire [DW-1:0] din    = stab_ff[DW-1:0];
    wire [7:0]    code   = din[camcap_pkg::LANE8_LO +: 8];

    // Edge detectors keep raw levels, so a polarity swap fakes no edge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pclk_prev_ff <= 1'b0;
            fs_prev_ff   <= 1'b0;
            ls_prev_ff   <= 1'b0;
        end else begin
            pclk_prev_ff <= pclk_q;
            fs_prev_ff   <= stab_ff[FS_IDX];
            ls_prev_ff   <= stab_ff[LS_IDX];
        end
    end

    wire pclk_rise = pclk_q & ~pclk_prev_ff;
    wire fs_rise   = fs_lvl & ~(fs_prev_ff ^ invert_frame_sync);
    wire ls_rise   = ls_lvl & ~(ls_prev_ff ^ invert_line_sync);

    // Timing mode follows the format select
    wire wide1120 = (fmt_sel == camcap_pkg::FMT_YCC16_1120) |
                    (fmt_sel == camcap_pkg::FMT_YCC20_1120);
    wire embedded = wide1120 |
                    (fmt_sel == camcap_pkg::FMT_YCC8_656);

    // Embedded code preamble tracking; pin syncs are ignored here
    wire emb_tick = embedded & pclk_rise;
    wire is_pre   = (code == camcap_pkg::CODE_PRE);
    wire is_zero  = (code == camcap_pkg::CODE_ZERO);
    wire timing_word = (seq_ff == camcap_pkg::SEQ_Z2) | is_pre |
                       (is_zero & ((seq_ff == camcap_pkg::SEQ_FF) |
                                   (seq_ff == camcap_pkg::SEQ_Z1)));
    camcap_pkg::camcap_seq_t nxt_seq;
    assign nxt_seq = (seq_ff == camcap_pkg::SEQ_Z2) ? camcap_pkg::SEQ_IDLE :
                     is_pre ? camcap_pkg::SEQ_FF :
                     (is_zero & (seq_ff == camcap_pkg::SEQ_FF)) ?
                         camcap_pkg::SEQ_Z1 :
                     (is_zero & (seq_ff == camcap_pkg::SEQ_Z1)) ?
                         camcap_pkg::SEQ_Z2 : camcap_pkg::SEQ_IDLE;

    // Status word decode: SAV opens a line outside vertical blanking, EAV closes it
    wire xy_take = emb_tick & (seq_ff == camcap_pkg::SEQ_Z2);
    wire xy_v    = code[camcap_pkg::XY_V_BIT];
    wire sav     = xy_take & ~code[camcap_pkg::XY_H_BIT];
    wire eav     = xy_take & code[camcap_pkg::XY_H_BIT];
    wire nxt_active = sav ? ~xy_v : (eav ? 1'b0 : active_ff);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            seq_ff    <= camcap_pkg::SEQ_IDLE;
            v_ff      <= 1'b1;
            active_ff <= 1'b0;
        end else if (emb_tick) begin
            seq_ff    <= nxt_seq;
            v_ff      <= xy_take ? xy_v : v_ff;
            active_ff <= nxt_active;
        end else if (!embedded) begin
            seq_ff    <= camcap_pkg::SEQ_IDLE;
            active_ff <= 1'b0;
        end
    end

    // Frame and line events in either mode
    wire frame_evt = embedded ? (sav & ~xy_v & v_ff) : fs_rise;
    wire line_evt  = embedded ? (sav & ~xy_v) : ls_rise;
    // Gated words only while line sync is high; codes never pass
    wire word_take = pclk_rise & (embedded ? (active_ff & ~timing_word)
                                           : ls_lvl);

    // Words per pixel; BT.1120 carries both components each cycle
    wire three_c = (fmt_sel == camcap_pkg::FMT_RGB565_3C) |
                   (fmt_sel == camcap_pkg::FMT_RGB666_3C) |
                   (fmt_sel == camcap_pkg::FMT_RGB888_3C);
    wire two_c   = (fmt_sel == camcap_pkg::FMT_RGB565_2C) |
                   (fmt_sel == camcap_pkg::FMT_YCC8_656);
    wire [1:0] cyc_need  = three_c ? 2'h3 : (two_c ? 2'h2 : 2'h1);
    wire [1:0] phase_cur = line_evt ? 2'h0 : phase_ff;
    wire       last_word = (phase_cur + 2'h1) == cyc_need;
    wire       emit      = word_take & last_word;
    wire       push      = emit & fifo_ready;

    // Color extension helpers
    function automatic logic [7:0] camcap_ext5(input logic [4:0] x);
        camcap_ext5 = {x, x[4:2]};
    endfunction : camcap_ext5

    function automatic logic [7:0] camcap_ext6(input logic [5:0] x);
        camcap_ext6 = {x, x[5:4]};
    endfunction : camcap_ext6

    // Pin mapping into components a (R or Y), b (G or C), c (B)
    function automatic logic [3*CW-1:0] camcap_map(
        input camcap_pkg::camcap_fmt_t f,
        input logic [7:0]              a0,
        input logic [7:0]              a1,
        input logic [DW-1:0]           d,
        input logic                    gen
    );
        logic [7:0] c8;
        logic [4:0] r5, b5;
        logic [5:0] g6;
        c8 = d[camcap_pkg::LANE8_LO +: 8];
        r5 = d[camcap_pkg::R16_LO +: 5];
        g6 = d[camcap_pkg::G16_LO +: 6];
        b5 = d[camcap_pkg::B16_LO +: 5];
        case (f)
            camcap_pkg::FMT_RGB565_2C:
                camcap_map = {2'h0, camcap_ext5(c8[7:3]),
                              2'h0, camcap_ext6({c8[2:0], a0[7:5]}),
                              2'h0, camcap_ext5(a0[4:0])};
            camcap_pkg::FMT_RGB565_3C:
                camcap_map = {2'h0, camcap_ext5(a0[7:3]),
                              2'h0, camcap_ext6(a1[7:2]),
                              2'h0, camcap_ext5(c8[7:3])};
            camcap_pkg::FMT_RGB666_3C:
                camcap_map = {2'h0, camcap_ext6(a0[7:2]),
                              2'h0, camcap_ext6(a1[7:2]),
                              2'h0, camcap_ext6(c8[7:2])};
            camcap_pkg::FMT_RGB888_3C:
                camcap_map = {2'h0, a0, 2'h0, a1, 2'h0, c8};
            camcap_pkg::FMT_YCC8_656:
                camcap_map = {2'h0, c8, 2'h0, a0, 10'h000};
            camcap_pkg::FMT_RGB565_16:
                camcap_map = gen ?
                    {5'h00, r5, 4'h0, g6, 5'h00, b5} :
                    {2'h0, camcap_ext5(r5), 2'h0, camcap_ext6(g6),
                     2'h0, camcap_ext5(b5)};
            camcap_pkg::FMT_YCC16_GEN:
                camcap_map = {2'h0, c8, 2'h0,
                              d[camcap_pkg::C16_LO +: 8], 10'h000};
            camcap_pkg::FMT_YCC16_1120:
                camcap_map = {2'h0, c8, 2'h0,
                              d[camcap_pkg::C1120_LO +: 8], 10'h000};
            camcap_pkg::FMT_YCC20_1120:
                camcap_map = {d[camcap_pkg::Y20_LO +: 10],
                              d[camcap_pkg::C20_LO +: 10], 10'h000};
            default:
                camcap_map = '0;
        endcase
    endfunction : camcap_map

    // Markers ride on the first pixel after their event
    wire frame_pend_cur = frame_pend_ff | frame_evt;
    wire line_pend_cur  = line_pend_ff | line_evt;
    camcap_pkg::camcap_pix_t pix_new;
    assign pix_new = {frame_pend_cur, line_pend_cur,
                      camcap_map(fmt_sel, w0_ff, w1_ff, din, generic_en)};

    // Phase counter and held words of a multi-cycle pixel
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phase_ff <= 2'h0;
            w0_ff    <= 8'h00;
            w1_ff    <= 8'h00;
        end else if (word_take) begin
            phase_ff <= last_word ? 2'h0 : phase_cur + 2'h1;
            if (!last_word && phase_cur == 2'h0) w0_ff <= code;
            if (!last_word && phase_cur == 2'h1) w1_ff <= code;
        end else if (line_evt) begin
            phase_ff <= 2'h0;
        end
    end

    // Pending markers survive a dropped pixel; a push clears them, even in the cycle of a new event
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            frame_pend_ff <= 1'b0;
            line_pend_ff  <= 1'b0;
        end else begin
            frame_pend_ff <= frame_pend_cur & ~push;
            line_pend_ff  <= line_pend_cur & ~push;
        end
    end

    // Recovered syncs and sticky overflow, cleared per frame
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            frame_sync_out_ff <= 1'b0;
            line_sync_out_ff  <= 1'b0;
            overflow_ff       <= 1'b0;
        end else begin
            frame_sync_out_ff <= embedded ? ~v_ff : fs_lvl;
            line_sync_out_ff  <= embedded ? active_ff : ls_lvl;
            overflow_ff <= (emit & ~fifo_ready) | (overflow_ff & ~frame_evt);
        end
    end

    assign frame_sync_out = frame_sync_out_ff;
    assign line_sync_out  = line_sync_out_ff;
    assign overflow_out   = overflow_ff;

    // Sensor cannot be paused, so a full FIFO drops pixels
    camcap_fifo #(
        .WIDTH ($bits(camcap_pkg::camcap_pix_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_valid  (emit),
        .in_ready  (fifo_ready),
        .in_data   (pix_new),
        .out_valid (pix_valid),
        .out_ready (pix_ready),
        .out_data  (pix_out)
    );

    // Checks on capture behaviour
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    AST_FRAME_RISE: assert property (
        (!embedded && fs_rise) |=> frame_pend_ff || $past(push))
        else $error("gated frame start lost");
    AST_GATED_TAKE: assert property (
        (!embedded && ls_lvl && pclk_rise) |-> word_take)
        else $error("valid pixel clock not sampled");
    AST_LINE_LOW: assert property (
        (!embedded && !ls_lvl) |-> !word_take)
        else $error("capture while line sync low");
    AST_CODE_DROP: assert property (
        (embedded && timing_word) |-> !word_take)
        else $error("timing code passed as data");
    AST_SAV_OPEN: assert property (
        (sav && !xy_v) |=> active_ff ##1 line_sync_out_ff)
        else $error("SAV did not open the line");
    AST_EAV_CLOSE: assert property (
        eav |=> !active_ff)
        else $error("EAV did not close the line");
    AST_EXT565: assert property (
        (emit && fmt_sel == camcap_pkg::FMT_RGB565_3C)
        |-> pix_new.comp_a[2:0] == pix_new.comp_a[7:5])
        else $error("RGB565 extension wrong");
    AST_EXT666: assert property (
        (emit && fmt_sel == camcap_pkg::FMT_RGB666_3C)
        |-> pix_new.comp_b[1:0] == pix_new.comp_b[7:6])
        else $error("RGB666 extension wrong");
    AST_1120_EACH: assert property (
        (word_take && wide1120) |-> emit)
        else $error("BT.1120 word not a whole pixel");
    AST_656_PAIR: assert property (
        (word_take && fmt_sel == camcap_pkg::FMT_YCC8_656 && !line_evt
         && phase_ff == 2'h0) |-> !emit)
        else $error("BT.656 pixel emitted after one word");
    AST_OVERFLOW: assert property (
        (emit && !fifo_ready) |=> overflow_ff)
        else $error("dropped pixel not flagged");

    COV_GATED_FRAME: cover property (!embedded && fs_rise);
    COV_SAV: cover property (sav && !xy_v);
    COV_THREE: cover property (emit && three_c);
    COV_OVERFLOW: cover property (emit && !fifo_ready);
endmodule : camcap_top
`default_nettype wire

// ==== tb/camcap_sensor.sv ====
// Behavioural image sensor driving the capture port's pins
`timescale 1ns/10ps
`default_nettype none
module camcap_sensor (
    input  wire logic        clock,
    input  wire logic        inv_frame,
    input  wire logic        inv_line,
    output logic             pixel_clock_in,
    output logic             frame_sync_in,
    output logic             line_sync_in,
    output logic [19:0]      sensor_data_bus
);
    logic fs_lvl = 1'b0;
    logic ls_lvl = 1'b0;

    // Pin levels after the polarity the port is told to expect
    assign frame_sync_in = fs_lvl ^ inv_frame;
    assign line_sync_in  = ls_lvl ^ inv_line;

    // Clock stands still low between words
    initial begin
        pixel_clock_in  = 1'b0;
        sensor_data_bus = 20'h00000;
    end

    // One word: set four clock periods before the rise, held four periods after it
    task automatic word(input logic [19:0] d);
        @(negedge clock);
        sensor_data_bus = d;
        repeat (4) @(negedge clock);
        pixel_clock_in = 1'b1;
        repeat (4) @(negedge clock);
        pixel_clock_in  = 1'b0;
        sensor_data_bus = ~d; // Released bus never shows the old word
    endtask : word

    // Line sync held for the whole line
    task automatic line(input logic on);
        repeat (4) @(negedge clock);
        ls_lvl = on;
    endtask : line

    task automatic frame(input logic on);
        repeat (4) @(negedge clock);
        fs_lvl = on;
    endtask : frame

    // Timing code: preamble, then status word on the upper eight pins
    task automatic code(input logic [7:0] xy);
        word(20'hFF000);
        word(20'h00000);
        word(20'h00000);
        word({xy, 12'h000});
    endtask : code
endmodule : camcap_sensor
`default_nettype wire

// ==== tb/camcap_top_bench.sv ====
// Self-checking bench of the camera capture port
`timescale 1ns/10ps
`default_nettype none
module camcap_top_bench;
    localparam logic [19:0] W1 = 20'h7E3C5;
    logic                      clock;
    logic                      rst_n;
    logic                      pixel_clock_in;
    logic                      frame_sync_in;
    logic                      line_sync_in;
    logic [19:0]               sensor_data_bus;
    camcap_pkg::camcap_fmt_t   fmt_sel;
    logic                      generic_en;
    logic                      invert_frame_sync;
    logic                      invert_line_sync;
    camcap_pkg::camcap_pix_t   pix_out;
    camcap_pkg::camcap_pix_t   got[$];
    logic                      pix_valid;
    logic                      pix_ready;
    logic                      frame_sync_out;
    logic                      line_sync_out;
    logic                      overflow_out;
    int                        n_errors = 0;
    int                        tests_run = 0;
    int                        cycles = 0;

    camcap_top #(.FIFO_DEPTH(8)) u_camcap_top (
        .clock(clock), .rst_n(rst_n), .pixel_clock_in(pixel_clock_in),
        .frame_sync_in(frame_sync_in), .line_sync_in(line_sync_in),
        .sensor_data_bus(sensor_data_bus), .fmt_sel(fmt_sel),
        .generic_en(generic_en), .invert_frame_sync(invert_frame_sync),
        .invert_line_sync(invert_line_sync), .pix_out(pix_out),
        .pix_valid(pix_valid), .pix_ready(pix_ready),
        .frame_sync_out(frame_sync_out), .line_sync_out(line_sync_out),
        .overflow_out(overflow_out));

    camcap_sensor u_camcap_sensor (
        .clock(clock), .inv_frame(invert_frame_sync),
        .inv_line(invert_line_sync), .pixel_clock_in(pixel_clock_in),
        .frame_sync_in(frame_sync_in), .line_sync_in(line_sync_in),
        .sensor_data_bus(sensor_data_bus));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Collect every pixel handed over; a hang ends the run
    always @(posedge clock) begin
        cycles++;
        if (pix_valid === 1'b1 && pix_ready === 1'b1) got.push_back(pix_out);
        if (cycles == 20000) begin
            n_errors++;
            summarize();
        end
    end

    task automatic summarize();
        if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize

    task automatic check_pix(input camcap_pkg::camcap_pix_t g, e);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check_pix

    task automatic check_num(input logic [7:0] g, e);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check_num

    function automatic camcap_pkg::camcap_pix_t mk(input logic m,
        input logic [9:0] a, b, c);
        return {m, m, a, b, c};
    endfunction : mk

    // Expected component: copies of the top bits fill the low ones, except for RGB888
    function automatic logic [9:0] ext(input int k, input int n,
                                       input logic [7:0] x);
        if (k == 3) return {2'h0, x};
        if (k == 2 || n == 1) return {2'h0, x[7:2], x[7:6]};
        return {2'h0, x[7:3], x[7:5]};
    endfunction : ext

    // Gated line of one pixel, then a word with line sync low
    task automatic gated(input int k, input int nw, input logic [19:0] w[3],
                         input camcap_pkg::camcap_pix_t e);
        fmt_sel = camcap_pkg::camcap_fmt_t'(k);
        got.delete();
        u_camcap_sensor.frame(1'b1);
        u_camcap_sensor.line(1'b1);
        for (int i = 0; i < nw; i++) u_camcap_sensor.word(w[i]);
        check_num({6'h0, frame_sync_out, line_sync_out}, 8'h03);
        u_camcap_sensor.line(1'b0);
        u_camcap_sensor.word(w[0]); // Must be ignored
        u_camcap_sensor.frame(1'b0);
        repeat (12) @(negedge clock);
        check_num(8'(got.size()), 8'h01);
        check_pix(got[0], e);
    endtask : gated

    // Embedded line: blanking status, SAV, words, EAV
    task automatic emb(input int k, input int nw, input logic [19:0] w[2],
                       input camcap_pkg::camcap_pix_t e);
        fmt_sel = camcap_pkg::camcap_fmt_t'(k);
        got.delete();
        u_camcap_sensor.code(8'hB0);
        u_camcap_sensor.code(8'h80);
        repeat (6) @(negedge clock);
        check_num({6'h0, frame_sync_out, line_sync_out}, 8'h03);
        for (int i = 0; i < nw; i++) u_camcap_sensor.word(w[i]);
        u_camcap_sensor.code(8'h90);
        repeat (12) @(negedge clock);
        check_num({7'h0, line_sync_out}, 8'h00);
        check_num(8'(got.size()), 8'h01);
        check_pix(got[0], e);
    endtask : emb

    // Stalled consumer: buffer fills, drops, then drains whole
    task automatic fill_drain();
        fmt_sel = camcap_pkg::FMT_YCC16_GEN;
        got.delete();
        pix_ready = 1'b0;
        u_camcap_sensor.frame(1'b1);
        u_camcap_sensor.line(1'b1);
        for (int i = 0; i < 11; i++) u_camcap_sensor.word({8'(i), 12'h000});
        u_camcap_sensor.line(1'b0);
        u_camcap_sensor.frame(1'b0);
        repeat (8) @(negedge clock);
        check_num({7'h0, overflow_out}, 8'h01);
        check_num(8'(got.size()), 8'h00);
        pix_ready = 1'b1;
        repeat (20) @(negedge clock);
        check_num(8'(got.size()), 8'h09);
        check_pix(got[8], mk(1'b0, 10'h008, 10'h000, 10'h000));
        u_camcap_sensor.frame(1'b1);
        repeat (10) @(negedge clock);
        check_num({7'h0, overflow_out}, 8'h00);
        u_camcap_sensor.frame(1'b0);
    endtask : fill_drain

    initial begin
        rst_n             = 1'b0;
        fmt_sel           = camcap_pkg::FMT_RGB888_3C;
        generic_en        = 1'b1;
        invert_frame_sync = 1'b0;
        invert_line_sync  = 1'b0;
        pix_ready         = 1'b1;
        repeat (10) @(negedge clock);
        rst_n = 1'b1;
        repeat (8) @(negedge clock);
        gated(0, 2, '{20'hC9ABC, 20'h5AABC, 20'h00000}, mk(1'b1, 10'h05A,
            10'h059, 10'h04A));
        for (int k = 1; k <= 3; k++) begin
            gated(k, 3, '{20'hC9ABC, 20'h5AABC, 20'h36ABC}, mk(1'b1,
                ext(k, 0, 8'hC9), ext(k, 1, 8'h5A), ext(k, 2, 8'h36)));
        end
        gated(5, 1, '{W1, W1, W1}, mk(1'b1, {5'h0, W1[19:15]},
            {4'h0, W1[14:9]}, {5'h0, W1[8:4]}));
        generic_en = 1'b0;
        gated(5, 1, '{W1, W1, W1}, mk(1'b1, ext(1, 0, {W1[19:15], 3'h0}),
            ext(1, 1, {W1[14:9], 2'h0}), ext(1, 2, {W1[8:4], 3'h0})));
        invert_frame_sync = 1'b1;
        invert_line_sync  = 1'b1;
        gated(6, 1, '{W1, W1, W1}, mk(1'b1, 10'h07E, 10'h03C, 10'h000));
        invert_frame_sync = 1'b0;
        invert_line_sync  = 1'b0;
        emb(8, 1, '{20'h5A3C7, 20'h0}, mk(1'b1, 10'h168, 10'h3C7, 10'h0));
        emb(7, 1, '{20'h5AC03, 20'h0}, mk(1'b1, 10'h05A, 10'h000, 10'h0));
        emb(4, 2, '{20'h3C000, 20'h7A000}, mk(1'b1, 10'h07A, 10'h03C,
            10'h0));
        fill_drain();
        summarize();
    end
endmodule : camcap_top_bench
`default_nettype wire
